// ---- tof_defines.svh ----
// Register offsets, field positions and reset values of the capture sequencer
`ifndef TOF_DEFINES_SVH
`define TOF_DEFINES_SVH

`define OFS_OPCTL    8'h00
`define OFS_SEQCNT   8'h04
`define OFS_PHCNT    8'h08
`define OFS_IPC      8'h0c
`define OFS_IPX      8'h10
`define OFS_SYM      8'h14
`define OFS_FMT      8'h18
`define OFS_PERIOD   8'h1c
`define OFS_FREQ     8'h20
`define OFS_EXP      8'h30
`define OFS_OFFS     8'h40
`define OFS_STATUS   8'h50
`define OFS_SLOT     8'h60
`define GRP4_MASK    8'hf0
`define GRP8_MASK    8'he0

`define BIT_VIDEO    0
`define BIT_SWTRIG   1
`define BIT_OFFS_EN  0
`define BIT_SYM_EN   14
`define BIT_HDR      0
`define BIT_VERNIER  7

// Frequencies in units of Hz / 10000
`define FREQ_21M2    16'h0848
`define FREQ_41M2    16'h1018
`define FREQ_60M24   16'h1788
`define FREQ_80M32   16'h1f60

`define RST_SEQCNT   3'h1
`define MAX_SEQCNT   3'h4
`define MIN_COMBINE  3'h2
`define PH_BLUR      3'h2
`define PH_FULL      3'h4
`define RST_EXP      16'h03e8
`define RST_SYM      16'h0100
`define RST_PERIOD   32'h000f4240
`define FMT_DIST_AMP 8'h00
`define FMT_USER     8'hff
`define CH_LIMIT     8'h08

`endif

// ---- tof_pkg.sv ----
// Types shared by the capture sequencer modules
package tof_pkg;
  typedef enum logic [7:0] {
    CH_DIST      = 8'h00,
    CH_AMP       = 8'h01,
    CH_X         = 8'h02,
    CH_Y         = 8'h03,
    CH_Z         = 8'h04,
    CH_RAW_DEPTH = 8'h05,
    CH_RAW_PHASE = 8'h06,
    CH_CONF      = 8'h07
  } chan_id_t;
  typedef enum logic [1:0] {FI_21M2, FI_41M2, FI_60M24, FI_80M32} freq_idx_t;
  typedef enum logic {S_IDLE, S_BUSY} seq_state_t;
  typedef logic [7:0] chan_mask_t;
endpackage : tof_pkg

// ---- chan_if.sv ----
// Channel selection bundle between register file and channel resolver
interface chan_if;
  logic               [7:0] fmt;
  logic               [7:0] slot [8];
  tof_pkg::chan_mask_t      mask;
  tof_pkg::chan_mask_t      signed_m;
  tof_pkg::chan_mask_t      byte_m;
  modport cfg (output fmt, output slot, input mask, input signed_m, input byte_m);
  modport res (input fmt, input slot, output mask, output signed_m, output byte_m);
endinterface : chan_if

// ---- freq_snap.sv ----
// Snaps a requested modulation frequency to the nearest achievable one
`include "tof_defines.svh"
module freq_snap (
  input  wire logic          [15:0] req,
  output logic               [15:0] freq,
  output tof_pkg::freq_idx_t        idx
);
  localparam logic [15:0] MID0 = 16'((32'(`FREQ_21M2) + 32'(`FREQ_41M2)) >> 1);
  localparam logic [15:0] MID1 = 16'((32'(`FREQ_41M2) + 32'(`FREQ_60M24)) >> 1);
  localparam logic [15:0] MID2 = 16'((32'(`FREQ_60M24) + 32'(`FREQ_80M32)) >> 1);

  always_comb begin
    if (req < MID0) begin
      freq = `FREQ_21M2;
      idx  = tof_pkg::FI_21M2;
    end else if (req < MID1) begin
      freq = `FREQ_41M2;
      idx  = tof_pkg::FI_41M2;
    end else if (req < MID2) begin
      freq = `FREQ_60M24;
      idx  = tof_pkg::FI_60M24;
    end else begin
      freq = `FREQ_80M32;
      idx  = tof_pkg::FI_80M32;
    end
  end
endmodule : freq_snap

// ---- chan_list.sv ----
// Resolves the output format selector and slots into a channel mask
`include "tof_defines.svh"
module chan_list #(
  parameter logic [7:0] SUPPORTED = 8'hff
) (
  chan_if.res cif
);
  localparam logic [7:0] M_DIST = 8'h01;
  localparam logic [7:0] M_AMP  = 8'h02;
  localparam logic [7:0] M_XYZ  = 8'h1c;
  localparam logic [7:0] M_Z    = 8'h10;
  localparam logic [7:0] M_RDEP = 8'h20;
  localparam logic [7:0] M_PH   = 8'h40;
  localparam logic [7:0] M_CONF = 8'h80;

  always_comb begin
    logic [7:0] sel;
    logic [7:0] m;
    sel = '0;
    m   = '0;
    // Set-bit union: duplicates collapse, slot order is irrelevant
    for (int i = 0; i < 8; i++) begin
      if (cif.slot[i] < `CH_LIMIT) begin
        sel[cif.slot[i][2:0]] = 1'b1;
      end
    end
    sel = sel & SUPPORTED;
    if (cif.fmt == `FMT_USER) begin
      m = (sel == 8'h00) ? M_DIST : sel;
    end else begin
      case (cif.fmt)
        8'h01:   m = M_DIST | M_AMP | M_CONF;
        8'h02:   m = M_XYZ;
        8'h03:   m = M_XYZ | M_AMP;
        8'h04:   m = M_PH;
        8'h05:   m = M_DIST | M_XYZ;
        8'h06:   m = M_Z | M_AMP;
        8'h07:   m = M_DIST;
        8'h08:   m = M_RDEP | M_AMP;
        8'h09:   m = M_AMP;
        default: m = M_DIST | M_AMP;
      endcase
    end
    cif.mask     = m;
    cif.signed_m = m & M_XYZ;
    cif.byte_m   = m & M_CONF;
  end
endmodule : chan_list

// ---- tof_capture_sequencer.sv ----
// Capture sequencing, channel selection and distance offset for a ToF camera
//
// Overview of operation
// - Modulation frequency resets to 41.2 MHz.
// - Written frequencies snap to achievable set.
// - Frequency unit Hz/10000; read returns selection.
// - One to four sequences, back to back.
// - Each sequence own exposure and frequency.
// - Each sequence one frame, header carries index.
// - Video mode by default, frames at period.
// - Manual mode: software or hardware trigger.
// - Each trigger captures current sequence count.
// - Up to eight channels, default distance+amplitude.
// - Channel word encodings and signedness per type.
// - Duplicate slot selections output only once.
// - Empty slot list gives distance channel.
// - Unproducible channels skipped, order irrelevant.
// - Slots apply only with user-defined format.
// - Bit 14 enables phase symmetry check.
// - Symmetry check only with four phases.
// - Phase count two enables low motion blur.
// - Per-frequency millimetre offsets correct distances.
// - Extended bit 7 merges sequence pairs.
// - Extended bit 0 merges all sequences weighted.
`include "tof_defines.svh"
module tof_capture_sequencer #(
  parameter logic [7:0] SUPPORTED_CH = 8'hff
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_trigger,
  input  wire logic        capture_done,
  output logic             capture_start,
  output logic      [1:0]  capture_seq,
  output logic      [15:0] capture_freq,
  output logic      [15:0] capture_exposure,
  output logic             frame_valid,
  output logic      [1:0]  frame_seq_index,
  output logic      [7:0]  channel_mask,
  output logic      [7:0]  channel_signed,
  output logic      [7:0]  channel_byte,
  output logic             symmetry_check_en,
  output logic      [15:0] symmetry_limit,
  output logic             low_motion_blur,
  input  wire logic        dist_valid_in,
  input  wire logic [15:0] dist_in,
  output logic             dist_valid_out,
  output logic      [15:0] dist_out
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                   pready_q;
  logic                   pslverr_q;
  logic [31:0]            prdata_q;
  logic                   video_q;
  logic                   swtrig_q;
  logic [2:0]             seqcnt_q;
  logic [2:0]             phcnt_q;
  logic [15:0]            ipc_q;
  logic [7:0]             ipx_q;
  logic [15:0]            sym_q;
  logic [7:0]             fmt_q;
  logic [31:0]            period_q;
  logic [15:0]            freq_q [4];
  tof_pkg::freq_idx_t     fidx_q [4];
  logic [15:0]            exp_q  [4];
  logic [15:0]            offs_q [4];
  logic [7:0]             slot_q [8];
  logic                   freq_touched_q;
  logic                   acc;
  logic                   wr_en;
  logic                   mapped;
  logic [31:0]            rdat;
  logic [15:0]            snap_f;
  tof_pkg::freq_idx_t     snap_i;
  tof_pkg::seq_state_t    state_q;
  logic [1:0]             seq_q;
  logic [1:0]             nlast_q;
  logic                   hdr_act_q;
  logic                   ver_act_q;
  logic [31:0]            vcnt_q;
  logic                   pend_q;
  logic                   hw_q;
  logic                   tick;
  logic                   trig;
  logic                   take;
  logic                   last;
  logic                   advance;
  logic                   emit;
  logic [1:0]             nidx;
  logic                   start_q;
  logic [1:0]             cseq_q;
  logic [15:0]            cfreq_q;
  logic [15:0]            cexp_q;
  logic                   fvalid_q;
  logic [1:0]             fidx_out_q;
  tof_pkg::chan_mask_t    mask_q;
  tof_pkg::chan_mask_t    signed_q;
  tof_pkg::chan_mask_t    byte_q;
  logic                   symen_q;
  logic                   blur_q;
  logic                   dvalid_q;
  logic [15:0]            dout_q;

  chan_if cif ();

  // ****************************************************************
  // APB slave, one wait state per access
  // ****************************************************************
  assign acc   = psel & penable & pready_q;
  assign wr_en = acc & pwrite;

  always_comb begin
    mapped = 1'b1;
    rdat   = '0;
    if ((paddr & `GRP8_MASK) == `OFS_SLOT) begin
      rdat = {24'h000000, slot_q[paddr[4:2]]};
    end else if ((paddr & `GRP4_MASK) == `OFS_FREQ) begin
      rdat = {16'h0000, freq_q[paddr[3:2]]};
    end else if ((paddr & `GRP4_MASK) == `OFS_EXP) begin
      rdat = {16'h0000, exp_q[paddr[3:2]]};
    end else if ((paddr & `GRP4_MASK) == `OFS_OFFS) begin
      rdat = {16'h0000, offs_q[paddr[3:2]]};
    end else begin
      case (paddr)
        `OFS_OPCTL:  rdat = {31'h00000000, video_q};
        `OFS_SEQCNT: rdat = {29'h00000000, seqcnt_q};
        `OFS_PHCNT:  rdat = {29'h00000000, phcnt_q};
        `OFS_IPC:    rdat = {16'h0000, ipc_q};
        `OFS_IPX:    rdat = {24'h000000, ipx_q};
        `OFS_SYM:    rdat = {16'h0000, sym_q};
        `OFS_FMT:    rdat = {24'h000000, fmt_q};
        `OFS_PERIOD: rdat = period_q;
        `OFS_STATUS: rdat = {16'h0000, mask_q, 3'h0, ver_act_q, hdr_act_q, seq_q,
                             state_q == tof_pkg::S_BUSY};
        default:     mapped = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (ce) begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        prdata_q  <= pwrite ? 32'h00000000 : rdat;
        pslverr_q <= ~mapped;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  freq_snap u_snap (
    .req  (pwdata[15:0]),
    .freq (snap_f),
    .idx  (snap_i)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_q        <= 1'b1;
      seqcnt_q       <= `RST_SEQCNT;
      phcnt_q        <= `PH_FULL;
      ipc_q          <= '0;
      ipx_q          <= '0;
      sym_q          <= `RST_SYM;
      fmt_q          <= `FMT_DIST_AMP;
      period_q       <= `RST_PERIOD;
      freq_touched_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        freq_q[i] <= `FREQ_41M2;
        fidx_q[i] <= tof_pkg::FI_41M2;
        exp_q[i]  <= `RST_EXP;
        offs_q[i] <= '0;
      end
      for (int i = 0; i < 8; i++) begin
        slot_q[i] <= '0;
      end
    end else if (ce && wr_en) begin
      if ((paddr & `GRP8_MASK) == `OFS_SLOT) begin
        slot_q[paddr[4:2]] <= pwdata[7:0];
      end else if ((paddr & `GRP4_MASK) == `OFS_FREQ) begin
        freq_q[paddr[3:2]] <= snap_f;
        fidx_q[paddr[3:2]] <= snap_i;
        freq_touched_q     <= freq_touched_q | (paddr[3:2] == 2'h0);
      end else if ((paddr & `GRP4_MASK) == `OFS_EXP) begin
        exp_q[paddr[3:2]] <= pwdata[15:0];
      end else if ((paddr & `GRP4_MASK) == `OFS_OFFS) begin
        offs_q[paddr[3:2]] <= pwdata[15:0];
      end else begin
        case (paddr)
          `OFS_OPCTL: video_q <= pwdata[`BIT_VIDEO];
          `OFS_SEQCNT: begin
            if (pwdata[31:0] == 32'h00000000) begin
              seqcnt_q <= `RST_SEQCNT;
            end else if (pwdata > 32'(`MAX_SEQCNT)) begin
              seqcnt_q <= `MAX_SEQCNT;
            end else begin
              seqcnt_q <= pwdata[2:0];
            end
          end
          `OFS_PHCNT: begin
            // Only the two legal phase counts are accepted
            if (pwdata == 32'(`PH_BLUR) || pwdata == 32'(`PH_FULL)) begin
              phcnt_q <= pwdata[2:0];
            end
          end
          `OFS_IPC:    ipc_q    <= pwdata[15:0];
          `OFS_IPX:    ipx_q    <= pwdata[7:0];
          `OFS_SYM:    sym_q    <= pwdata[15:0];
          `OFS_FMT:    fmt_q    <= pwdata[7:0];
          `OFS_PERIOD: period_q <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // Software trigger is a write-one pulse and reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swtrig_q <= 1'b0;
    end else if (ce) begin
      swtrig_q <= wr_en && paddr == `OFS_OPCTL && pwdata[`BIT_SWTRIG];
    end
  end

  // ****************************************************************
  // Trigger sources
  // ****************************************************************
  assign tick = video_q && vcnt_q == 32'h00000000;
  assign trig = ~video_q & (swtrig_q | (hw_trigger & ~hw_q));
  assign take = state_q == tof_pkg::S_IDLE && pend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcnt_q <= '0;
      hw_q   <= 1'b0;
      pend_q <= 1'b0;
    end else if (ce) begin
      hw_q <= hw_trigger;
      if (!video_q) begin
        vcnt_q <= '0;
      end else if (vcnt_q == 32'h00000000) begin
        vcnt_q <= period_q - 32'h00000001;
      end else begin
        vcnt_q <= vcnt_q - 32'h00000001;
      end
      // One request is held while a burst runs; a new event beats the take
      pend_q <= (pend_q & ~take) | tick | trig;
    end
  end

  // ****************************************************************
  // Sequence burst
  // ****************************************************************
  assign last    = seq_q == nlast_q;
  assign advance = state_q == tof_pkg::S_BUSY && capture_done && !last;
  assign nidx    = take ? 2'h0 : 2'(seq_q + 2'h1);
  assign emit    = hdr_act_q ? last : (ver_act_q ? seq_q[0] : 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= tof_pkg::S_IDLE;
      seq_q     <= '0;
      nlast_q   <= '0;
      hdr_act_q <= 1'b0;
      ver_act_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        tof_pkg::S_IDLE: begin
          if (take) begin
            state_q   <= tof_pkg::S_BUSY;
            seq_q     <= 2'h0;
            nlast_q   <= 2'(seqcnt_q - 3'h1);
            hdr_act_q <= ipx_q[`BIT_HDR] && seqcnt_q >= `MIN_COMBINE;
            ver_act_q <= ipx_q[`BIT_VERNIER] &&
                         (seqcnt_q == `MIN_COMBINE || seqcnt_q == `MAX_SEQCNT);
          end
        end
        tof_pkg::S_BUSY: begin
          if (capture_done) begin
            if (last) begin
              state_q <= tof_pkg::S_IDLE;
            end else begin
              seq_q <= nidx;
            end
          end
        end
      endcase
    end
  end

  // Next capture is issued the cycle after the previous one ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      cseq_q  <= '0;
      cfreq_q <= `FREQ_41M2;
      cexp_q  <= `RST_EXP;
    end else if (ce) begin
      start_q <= take | advance;
      if (take | advance) begin
        cseq_q  <= nidx;
        cfreq_q <= freq_q[nidx];
        cexp_q  <= exp_q[nidx];
      end
    end
  end

  // Merged frames report the first sequence of the merged group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fvalid_q   <= 1'b0;
      fidx_out_q <= '0;
    end else if (ce) begin
      fvalid_q <= state_q == tof_pkg::S_BUSY && capture_done && emit;
      if (state_q == tof_pkg::S_BUSY && capture_done) begin
        fidx_out_q <= hdr_act_q ? 2'h0 : (ver_act_q ? {seq_q[1], 1'b0} : seq_q);
      end
    end
  end

  // ****************************************************************
  // Channel selection and processing controls
  // ****************************************************************
  assign cif.fmt = fmt_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cif.slot[i] = slot_q[i];
    end
  end

  chan_list #(
    .SUPPORTED (SUPPORTED_CH)
  ) u_chan (
    .cif (cif.res)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q   <= '0;
      signed_q <= '0;
      byte_q   <= '0;
      symen_q  <= 1'b0;
      blur_q   <= 1'b0;
    end else if (ce) begin
      mask_q   <= cif.mask;
      signed_q <= cif.signed_m;
      byte_q   <= cif.byte_m;
      symen_q  <= ipc_q[`BIT_SYM_EN] && phcnt_q == `PH_FULL;
      blur_q   <= phcnt_q == `PH_BLUR;
    end
  end

  // Offset follows the frequency of the sequence last captured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dvalid_q <= 1'b0;
      dout_q   <= '0;
    end else if (ce) begin
      dvalid_q <= dist_valid_in;
      if (dist_valid_in) begin
        dout_q <= ipc_q[`BIT_OFFS_EN] ? 16'(dist_in + offs_q[fidx_q[seq_q]]) : dist_in;
      end
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign capture_start     = start_q;
  assign capture_seq       = cseq_q;
  assign capture_freq      = cfreq_q;
  assign capture_exposure  = cexp_q;
  assign frame_valid       = fvalid_q;
  assign frame_seq_index   = fidx_out_q;
  assign channel_mask      = mask_q;
  assign channel_signed    = signed_q;
  assign channel_byte      = byte_q;
  assign symmetry_check_en = symen_q;
  assign symmetry_limit    = sym_q;
  assign low_motion_blur   = blur_q;
  assign dist_valid_out    = dvalid_q;
  assign dist_out          = dout_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence s_mid_done;
    state_q == tof_pkg::S_BUSY && capture_done && !last;
  endsequence

  sequence s_pair_first;
    state_q == tof_pkg::S_BUSY && capture_done && ver_act_q && !hdr_act_q && !seq_q[0];
  endsequence

  chk_freq_default: assert property (!freq_touched_q |-> freq_q[0] == `FREQ_41M2)
    else $error("sequence 0 frequency left its reset value unwritten");
  chk_freq_legal: assert property (freq_q[1] inside {`FREQ_21M2, `FREQ_41M2,
                                   `FREQ_60M24, `FREQ_80M32})
    else $error("frequency register holds unachievable value");
  chk_seq_range: assert property (seqcnt_q >= 3'h1 && seqcnt_q <= `MAX_SEQCNT)
    else $error("sequence count out of range");
  chk_no_gap: assert property (s_mid_done |=> start_q && cseq_q == 2'($past(seq_q) + 2'h1))
    else $error("next sequence not started right after previous");
  chk_seq_params: assert property (take |=> start_q && cseq_q == 2'h0 &&
                                   cfreq_q == $past(freq_q[0]))
    else $error("first sequence not using base settings");
  chk_frame_index: assert property (state_q == tof_pkg::S_BUSY && capture_done &&
                                    !hdr_act_q && !ver_act_q
                                    |=> fvalid_q && fidx_out_q == $past(seq_q))
    else $error("frame missing or index wrong");
  // A remembered trigger may start a new burst at sequence 0 right away
  chk_burst_len: assert property (state_q == tof_pkg::S_BUSY && capture_done && last
                                  |=> state_q == tof_pkg::S_IDLE
                                  ##1 (!start_q || cseq_q == 2'h0))
    else $error("burst did not end after configured count");
  chk_video_blocks: assert property (video_q && swtrig_q && !pend_q && !tick &&
                                     state_q == tof_pkg::S_IDLE |=> !pend_q)
    else $error("manual trigger accepted in video mode");
  // Mask is zero in reset and first loads on the first edge after reset
  chk_mask_nonempty: assert property ($past(presetn) |-> mask_q != 8'h00)
    else $error("empty channel mask");
  chk_sym_gate: assert property (symen_q |-> phcnt_q == `PH_FULL || $past(phcnt_q) == `PH_FULL)
    else $error("symmetry check on without four phases");
  chk_pair_merge: assert property (s_pair_first |=> !fvalid_q)
    else $error("vernier emitted first sequence of a pair");
  chk_offset_add: assert property (dist_valid_in && ipc_q[`BIT_OFFS_EN] |=>
                                   dout_q == 16'($past(dist_in) + $past(offs_q[fidx_q[seq_q]])))
    else $error("distance offset not applied");
endmodule : tof_capture_sequencer

// ---- sensor_model.sv ----
// Behavioural sensor that answers each capture request
module sensor_model #(
  parameter int SLOW = 6
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic capture_start,
  output logic      capture_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Answer
  // ****
  int   cnt;
  logic slow_q;
  // Alternates prompt and slow answers to stress the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt          <= 0;
      slow_q       <= 1'b0;
      capture_done <= 1'b0;
    end else begin
      capture_done <= (cnt == 1);
      if (capture_start) begin
        cnt    <= slow_q ? SLOW : 2;
        slow_q <= !slow_q;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : sensor_model

// ---- tof_capture_sequencer_tb_top.sv ----
// Self-checking testbench for the capture sequencer
module tof_capture_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench
  // ****
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        hw_trigger = 0, dist_valid_in = 0, capture_done, pready, pslverr, err;
  logic        capture_start, frame_valid, symmetry_check_en, low_motion_blur, dist_valid_out;
  logic [7:0]  paddr = 0, channel_mask, channel_signed, channel_byte;
  logic [7:0]  slots [8] = '{8'h07, 8'h01, 8'h01, 8'h04, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [15:0] dist_in = 0, capture_freq, capture_exposure, symmetry_limit, dist_out, fq [4];
  logic [15:0] fe [4];
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0]  capture_seq, frame_seq_index, last_idx;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, n_start = 0, n_frame = 0, s0, f0;

  always #5 pclk = ~pclk;

  tof_capture_sequencer DUT (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hw_trigger, .capture_done, .capture_start,
    .capture_seq, .capture_freq, .capture_exposure, .frame_valid, .frame_seq_index,
    .channel_mask, .channel_signed, .channel_byte, .symmetry_check_en, .symmetry_limit,
    .low_motion_blur, .dist_valid_in, .dist_in, .dist_valid_out, .dist_out);
  sensor_model PART (.pclk, .presetn, .capture_start, .capture_done);

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (capture_start) begin
      n_start <= n_start + 1;
      fq[capture_seq] <= capture_freq;
      fe[capture_seq] <= capture_exposure;
    end
    if (frame_valid) begin
      n_frame <= n_frame + 1;
      last_idx <= frame_seq_index;
    end
    if (cyc == 6000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // Fixed settle window: longest burst is four captures, two of them slow
  task automatic trig(input logic hw, input int ns, input int nf, input logic [1:0] idx);
    s0 = n_start;
    f0 = n_frame;
    if (hw) begin
      @(posedge pclk) hw_trigger <= 1;
      @(posedge pclk) hw_trigger <= 0;
    end else apb(1, 8'h00, 32'h2);
    repeat (150) @(posedge pclk);
    chk(n_start - s0, ns); chk(n_frame - f0, nf); chk(last_idx, idx);
  endtask : trig

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h20, 0); chk(rd, 32'h1018);
    chk(channel_mask, 8'h03);
    chk(n_start > 0, 1);
    chk(symmetry_limit, 32'h0100);
    apb(1, 8'h00, 32'h3);
    apb(0, 8'h54, 0); chk({rd[0], err}, 2'b01);
    apb(1, 8'h00, 0);
    apb(1, 8'h20, 32'h1f60);
    apb(1, 8'h24, 32'h0850);
    apb(0, 8'h24, 0); chk(rd, 32'h0848);
    chk(n_start, 1);
    apb(1, 8'h34, 32'hc8);
    apb(1, 8'h04, 3);
    trig(0, 3, 3, 2);
    chk({fq[0], fq[1]}, 32'h1f600848);
    chk({fe[0], fe[1]}, 32'h03e800c8);
    apb(1, 8'h28, 32'h1f60);
    apb(1, 8'h2c, 32'h0848);
    apb(1, 8'h04, 4);
    apb(1, 8'h10, 32'h80);
    trig(1, 4, 2, 2);
    apb(1, 8'h04, 2);
    apb(1, 8'h10, 32'h1);
    trig(0, 2, 1, 0);
    apb(1, 8'h0c, 32'h4001);
    repeat (3) @(posedge pclk);
    chk(symmetry_check_en, 1);
    apb(1, 8'h08, 2);
    repeat (3) @(posedge pclk);
    chk({symmetry_check_en, low_motion_blur}, 2'b01);
    // Sequence 1 last ran at 21.2 MHz, so the first offset applies
    for (int i = 0; i < 4; i++) apb(1, 8'h40 + 8'(4 * i), 32'(i + 1));
    @(posedge pclk) dist_valid_in <= 1;
    dist_in <= 16'h0064;
    @(posedge pclk) dist_valid_in <= 0;
    @(posedge pclk) chk({dist_valid_out, dist_out}, 17'h10065);
    apb(1, 8'h18, 32'hff);
    for (int i = 0; i < 8; i++) apb(1, 8'h60 + 8'(4 * i), slots[i]);
    repeat (3) @(posedge pclk);
    chk({channel_mask, channel_signed, channel_byte}, 24'h921080);
    for (int i = 0; i < 4; i++) apb(1, 8'h60 + 8'(4 * i), 32'hff);
    repeat (3) @(posedge pclk);
    chk(channel_mask, 8'h01);
    apb(1, 8'h18, 0);
    repeat (3) @(posedge pclk);
    chk(channel_mask, 8'h03);
    apb(1, 8'h18, 32'h2);
    repeat (3) @(posedge pclk);
    chk({channel_mask, channel_signed}, 16'h1c1c);
    // Two-sequence bursts fit inside a 20-cycle period: five ticks in 100 cycles
    apb(1, 8'h1c, 32'h14);
    apb(1, 8'h00, 32'h1);
    s0 = n_start;
    repeat (100) @(posedge pclk);
    chk(n_start - s0, 10);
    apb(1, 8'h04, 32'h9);
    apb(0, 8'h04, 0); chk(rd, 32'h4);
    results();
  end
endmodule : tof_capture_sequencer_tb_top
